// [design/tlr_pkg.sv]
package tlr_pkg;
    localparam logic [1:0]  PTR_TEMP      = 2'h0;
    localparam logic [1:0]  PTR_CONFIG    = 2'h1;
    localparam logic [1:0]  PTR_LOW_LIM   = 2'h2;
    localparam logic [1:0]  PTR_HIGH_LIM  = 2'h3;
    localparam logic [15:0] LOW_LIM_RST   = 16'h4B00;
    localparam logic [15:0] HIGH_LIM_RST  = 16'h5000;
    localparam logic [15:0] CONFIG_RST    = 16'h0000;
    localparam logic [15:0] LIMIT_MASK    = 16'hFFF0;
    localparam int          INT_MSB       = 15;
    localparam int          INT_LSB       = 8;
    localparam int          FRAC_MSB      = 7;
    localparam int          FRAC_LSB      = 4;
    localparam int          CFG_TM_BIT    = 9;
    localparam int          CFG_POL_BIT   = 10;
    localparam logic [15:0] CONFIG_MASK   = 16'h0600;
    localparam logic [3:0]  DEV_ADDR_BASE = 4'h9;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
endpackage : tlr_pkg

// [design/tlr_regmem.sv]
`timescale 1ns/1ns
module tlr_regmem #(
    parameter int DEPTH = 4
) (
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [15:0]              wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [15:0]              rd_data
);
    logic [15:0] mem_q [DEPTH];
    function automatic logic [15:0] rst_val(input int idx);
        case (idx)
            2:       rst_val = tlr_pkg::LOW_LIM_RST;
            3:       rst_val = tlr_pkg::HIGH_LIM_RST;
            default: rst_val = tlr_pkg::CONFIG_RST;
        endcase
    endfunction : rst_val
    function automatic logic [15:0] wr_mask(input int idx);
        case (idx)
            1:       wr_mask = tlr_pkg::CONFIG_MASK;
            2, 3:    wr_mask = tlr_pkg::LIMIT_MASK;
            default: wr_mask = 16'h0000;
        endcase
    endfunction : wr_mask
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_word
            always_ff @(posedge clk_sys)
            begin
                if (srst)
                    mem_q[gi] <= rst_val(gi);
                else if (wr_en && (int'(wr_addr) == gi))
                    // reserved low nibble never stored
                    mem_q[gi] <= wr_data & wr_mask(gi);
            end
        end
    endgenerate
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rd_data <= 16'h0000;
        else
            rd_data <= mem_q[rd_addr];
    end
endmodule : tlr_regmem

// [design/tlr_top.sv]
// Notes on behaviour
// - low limit register at pointer 2, reset 4B00h meaning 75 degrees.
// - high limit register at pointer 3, reset 5000h meaning 80 degrees.
// - limit bits 15..8 are the integer part, one degree per step.
// - limit bits 7..4 are the fraction, sixteenth of a degree each.
// - three strap pins pick one of eight bus addresses.
// - data and alert pins only pull low or release.
// - alert wires of many devices may be tied together.
// - thermostat bit zero gives comparator alert, one gives interrupt alert.
// - polarity bit zero gives active-low alert, one active-high.
`timescale 1ns/1ns
module tlr_top (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        addr_strap_0,
    input  wire logic        addr_strap_1,
    input  wire logic        addr_strap_2,
    input  wire logic [15:0] temp_value,
    input  wire logic        temp_valid,
    output logic             alert_out,
    output logic             alert_oe,
    output logic [15:0]      low_limit_q,
    output logic [15:0]      high_limit_q
);
    typedef enum logic [2:0] {
        TLR_IDLE, TLR_START, TLR_ADDR, TLR_ACK, TLR_WRX, TLR_WACK, TLR_RDX, TLR_RACK
    } tlr_state_e;

    logic [1:0]  scl_sy_q, sda_sy_q;
    logic        scl_d1_q, sda_d1_q;
    logic [2:0]  strap_q;
    logic [2:0]  strap_sy_q, strap_s1_q;
    tlr_state_e  st_q;
    logic [2:0]  bit_q;
    logic [7:0]  sh_q;
    logic        rw_q;
    logic [1:0]  ptr_q;
    logic [1:0]  wbyte_q;
    logic [7:0]  wmsb_q;
    logic        rbyte_q;
    logic        wr_q;
    logic [15:0] wdat_q;
    logic [15:0] rd_data;
    logic [15:0] cfg_shadow_q;
    logic        alert_act_q;
    logic        scl_rise, scl_fall, start_c, stop_c;
    logic [6:0]  my_addr;

    // pins are asynchronous: two flops before use
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            scl_sy_q   <= 2'h3;
            sda_sy_q   <= 2'h3;
            strap_s1_q <= 3'h0;
            strap_sy_q <= 3'h0;
        end
        else
        begin
            scl_sy_q   <= {scl_sy_q[0], scl_in};
            sda_sy_q   <= {sda_sy_q[0], sda_in};
            strap_s1_q <= {addr_strap_2, addr_strap_1, addr_strap_0};
            strap_sy_q <= strap_s1_q;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end
        else
        begin
            scl_d1_q <= scl_sy_q[1];
            sda_d1_q <= sda_sy_q[1];
        end
    end

    // strap is sampled continuously after reset; boards tie it fixed
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            strap_q <= 3'h0;
        else
            strap_q <= strap_sy_q;
    end

    assign scl_rise = scl_sy_q[1] & ~scl_d1_q;
    assign scl_fall = ~scl_sy_q[1] & scl_d1_q;
    assign start_c  = scl_sy_q[1] & scl_d1_q & ~sda_sy_q[1] & sda_d1_q;
    assign stop_c   = scl_sy_q[1] & scl_d1_q & sda_sy_q[1] & ~sda_d1_q;
    assign my_addr  = {tlr_pkg::DEV_ADDR_BASE, strap_q};

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_q    <= TLR_IDLE;
            bit_q   <= 3'h0;
            sh_q    <= tlr_pkg::ZERO_BYTE;
            rw_q    <= 1'b0;
            ptr_q   <= tlr_pkg::PTR_TEMP;
            wbyte_q <= 2'h0;
            wmsb_q  <= tlr_pkg::ZERO_BYTE;
            rbyte_q <= 1'b0;
            wr_q    <= 1'b0;
            wdat_q  <= 16'h0000;
        end
        else
        begin
            wr_q <= 1'b0;
            if (start_c)
            begin
                st_q    <= TLR_START;
                bit_q   <= 3'h0;
                wbyte_q <= 2'h0;
                rbyte_q <= 1'b0;
            end
            else if (stop_c)
                st_q <= TLR_IDLE;
            else if (scl_rise)
            begin
                case (st_q)
                    TLR_ADDR, TLR_WRX:
                    begin
                        sh_q  <= {sh_q[6:0], sda_sy_q[1]};
                        bit_q <= bit_q + 3'h1;
                    end
                    TLR_RACK:
                        // master nack ends the read
                        if (sda_sy_q[1])
                            st_q <= TLR_IDLE;
                    default:
                        bit_q <= bit_q + ((st_q == TLR_RDX) ? 3'h1 : 3'h0);
                endcase
            end
            else if (scl_fall)
            begin
                case (st_q)
                    // first fall after start carries no bit; skip it
                    TLR_START:
                        st_q <= TLR_ADDR;
                    TLR_ADDR:
                        if (bit_q == 3'h0)
                        begin
                            if (sh_q[7:1] == my_addr)
                            begin
                                rw_q <= sh_q[0];
                                st_q <= TLR_ACK;
                            end
                            else
                                st_q <= TLR_IDLE;
                        end
                    TLR_ACK:
                        st_q <= rw_q ? TLR_RDX : TLR_WRX;
                    TLR_WRX:
                        if (bit_q == 3'h0)
                        begin
                            st_q <= TLR_WACK;
                            if (wbyte_q == 2'h0)
                                ptr_q <= sh_q[1:0];
                            else if (wbyte_q == 2'h1)
                                wmsb_q <= sh_q;
                            else
                            begin
                                wdat_q <= {wmsb_q, sh_q};
                                wr_q   <= (ptr_q != tlr_pkg::PTR_TEMP);
                            end
                        end
                    TLR_WACK:
                    begin
                        st_q    <= TLR_WRX;
                        wbyte_q <= (wbyte_q == 2'h2) ? 2'h2 : wbyte_q + 2'h1;
                    end
                    TLR_RDX:
                        if (bit_q == 3'h0)
                        begin
                            st_q    <= TLR_RACK;
                            rbyte_q <= ~rbyte_q;
                        end
                    TLR_RACK:
                        st_q <= TLR_RDX;
                    default:
                        st_q <= TLR_IDLE;
                endcase
            end
        end
    end

    tlr_regmem #(
        .DEPTH   (4)
    ) u_regs (
        .clk_sys (clk_sys),
        .srst    (srst),
        .wr_en   (wr_q),
        .wr_addr (ptr_q),
        .wr_data (wdat_q),
        .rd_addr (ptr_q),
        .rd_data (rd_data)
    );

    // config copy kept here so mode bits steer alert without a read port
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cfg_shadow_q <= tlr_pkg::CONFIG_RST;
        else if (wr_q && ptr_q == tlr_pkg::PTR_CONFIG)
            cfg_shadow_q <= wdat_q & tlr_pkg::CONFIG_MASK;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            low_limit_q  <= tlr_pkg::LOW_LIM_RST;
            high_limit_q <= tlr_pkg::HIGH_LIM_RST;
        end
        else if (wr_q)
        begin
            if (ptr_q == tlr_pkg::PTR_LOW_LIM)
            begin
                low_limit_q[tlr_pkg::INT_MSB:tlr_pkg::INT_LSB] <=
                    wdat_q[tlr_pkg::INT_MSB:tlr_pkg::INT_LSB];
                low_limit_q[tlr_pkg::FRAC_MSB:tlr_pkg::FRAC_LSB] <=
                    wdat_q[tlr_pkg::FRAC_MSB:tlr_pkg::FRAC_LSB];
            end
            if (ptr_q == tlr_pkg::PTR_HIGH_LIM)
            begin
                high_limit_q[tlr_pkg::INT_MSB:tlr_pkg::INT_LSB] <=
                    wdat_q[tlr_pkg::INT_MSB:tlr_pkg::INT_LSB];
                high_limit_q[tlr_pkg::FRAC_MSB:tlr_pkg::FRAC_LSB] <=
                    wdat_q[tlr_pkg::FRAC_MSB:tlr_pkg::FRAC_LSB];
            end
        end
    end

    // alert event: comparator holds with hysteresis, interrupt clears on any read
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            alert_act_q <= 1'b0;
        else if (temp_valid &&
                 $signed(temp_value & tlr_pkg::LIMIT_MASK) >= $signed(high_limit_q))
            alert_act_q <= 1'b1;
        else if (!cfg_shadow_q[tlr_pkg::CFG_TM_BIT])
        begin
            if (temp_valid &&
                $signed(temp_value & tlr_pkg::LIMIT_MASK) < $signed(low_limit_q))
                alert_act_q <= 1'b0;
        end
        else if (st_q == TLR_ACK && rw_q)
            alert_act_q <= 1'b0;
    end

    // open drain: only ever drive zero; active level through enable
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            alert_out <= 1'b0;
            alert_oe  <= 1'b0;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
        end
        else
        begin
            alert_out <= 1'b0;
            alert_oe  <= alert_act_q ^ cfg_shadow_q[tlr_pkg::CFG_POL_BIT];
            sda_out   <= 1'b0;
            case (st_q)
                TLR_ACK, TLR_WACK:
                    sda_oe <= 1'b1;
                TLR_RDX:
                    // bit index moves on rise; hold the pin until bus clock is low
                    if (!scl_d1_q)
                        sda_oe <= ~(rbyte_q ? rd_data[~bit_q] : rd_data[{1'b1, ~bit_q}]);
                default:
                    sda_oe <= 1'b0;
            endcase
        end
    end
endmodule : tlr_top

// [verif/tlr_top_asserts.sv]
`timescale 1ns/1ns
module tlr_top_chk (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        scl_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        alert_out,
    input wire logic        alert_oe,
    input wire logic [15:0] low_limit_q,
    input wire logic [15:0] high_limit_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    low_rsvd_a: assert property (low_limit_q[3:0] == 4'h0)
        else $error("low limit low nibble not zero");
    high_rsvd_a: assert property (high_limit_q[3:0] == 4'h0)
        else $error("high limit low nibble not zero");
    low_reset_a: assert property ($fell(srst) |-> low_limit_q == 16'h4B00)
        else $error("low limit reset value wrong");
    high_reset_a: assert property ($fell(srst) |-> high_limit_q == 16'h5000)
        else $error("high limit reset value wrong");
    drain_only_a: assert property (sda_out == 1'b0 && alert_out == 1'b0)
        else $error("open drain pin driven high");
    idle_release_a: assert property ($fell(srst) |-> !sda_oe && !alert_oe)
        else $error("pin pulled low after reset");
    limit_update_a: assert property (($changed(low_limit_q) || $changed(high_limit_q))
        |-> !scl_in && !$past(scl_in))
        else $error("limit changed outside bus low phase");
    data_phase_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data pin moved while bus clock high");
    cover property ($rose(sda_oe));
    cover property ($changed(high_limit_q));
    cover property ($rose(alert_oe));
endmodule : tlr_top_chk
bind tlr_top tlr_top_chk chk (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .low_limit_q(low_limit_q), .high_limit_q(high_limit_q));

// [verif/tlr_host.sv]
`timescale 1ns/1ns
module tlr_host #(
    parameter int HALF = 10
) (
    input  wire logic clk_sys,
    input  wire logic sda_in,
    output logic      scl_q,
    output logic      sda_pull_q
);
    initial
    begin
        scl_q      = 1'b1;
        sda_pull_q = 1'b0;
    end
    task automatic step(input logic s, input logic p);
        @(posedge clk_sys);
        scl_q      <= s;
        sda_pull_q <= p;
        repeat (HALF) @(posedge clk_sys);
    endtask : step
    // data only moves with clock low, else a false start or stop
    task automatic bitx(input logic b, output logic r);
        step(1'b0, sda_pull_q);
        step(1'b0, !b);
        step(1'b1, !b);
        r = sda_in;
    endtask : bitx
    task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q,
                          output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(last, ack);
    endtask : byte_x
    task automatic start;
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start
    task automatic stop;
        step(1'b0, sda_pull_q);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop
    task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                             output logic nak);
        logic [7:0] q;
        logic       n;
        start;
        byte_x({a, 1'b0}, 1'b1, q, nak);
        byte_x(p, 1'b1, q, n);
        byte_x(d[15:8], 1'b1, q, n);
        byte_x(d[7:0], 1'b1, q, n);
        stop;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
        logic [7:0] q;
        logic       n;
        start;
        byte_x({a, 1'b0}, 1'b1, q, n);
        byte_x(p, 1'b1, q, n);
        stop;
        start;
        byte_x({a, 1'b1}, 1'b1, q, n);
        byte_x(8'hFF, 1'b0, d[15:8], n);
        byte_x(8'hFF, 1'b1, d[7:0], n);
        stop;
    endtask : read_reg
endmodule : tlr_host

// [verif/tb_top.sv]
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    logic        clk_sys    = 1'b0;
    logic        srst       = 1'b1;
    logic        temp_valid = 1'b0;
    logic [15:0] temp_value = 16'h0000;
    logic [2:0]  strap      = 3'h0;
    logic        scl_q;
    logic        sda_pull_q;
    logic        sda_oe;
    logic        alert_oe;
    logic        nak;
    logic [15:0] rd;
    int          failures    = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    // pull-ups give the high level of both shared wires
    wire         sda_w   = !(sda_pull_q || sda_oe);
    wire         alert_w = !alert_oe;
    tlr_top dut (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_q), .sda_in(sda_w),
        .sda_out(), .sda_oe(sda_oe), .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
        .addr_strap_2(strap[2]), .temp_value(temp_value), .temp_valid(temp_valid),
        .alert_out(), .alert_oe(alert_oe), .low_limit_q(), .high_limit_q());
    tlr_host host (.clk_sys(clk_sys), .sda_in(sda_w), .scl_q(scl_q), .sda_pull_q(sda_pull_q));
    always #10 clk_sys = ~clk_sys;
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            failures++;
            end_of_test;
        end
    end
    task automatic temp(input logic [15:0] v);
        @(posedge clk_sys);
        temp_value <= v;
        temp_valid <= 1'b1;
        @(posedge clk_sys);
        temp_valid <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : temp
    initial
    begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        host.read_reg({4'h9, strap}, 8'h02, rd);
        `CHK(rd, 16'h4B00)
        host.read_reg({4'h9, strap}, 8'h03, rd);
        `CHK(rd, 16'h5000)
        for (int a = 0; a < 8; a++)
        begin
            strap <= a[2:0];
            repeat (4) @(posedge clk_sys);
            host.write_reg({4'h9, a[2:0]}, 8'h03, {a[7:0], 8'h5F}, nak);
            `CHK(nak, 1'b0)
            host.write_reg({4'h9, a[2:0] ^ 3'h1}, 8'h03, 16'hFFFF, nak);
            `CHK(nak, 1'b1)
            `CHK(dut.high_limit_q, {a[7:0], 8'h50})
        end
        host.write_reg({4'h9, strap}, 8'h02, 16'hF23C, nak);
        `CHK(dut.low_limit_q, 16'hF230)
        host.read_reg({4'h9, strap}, 8'h02, rd);
        `CHK(rd, 16'hF230)
        // signed compare: F000 lies below F230, 0000 between the limits
        temp(16'h0800);
        `CHK(alert_w, 1'b0)
        temp(16'h0000);
        `CHK(alert_w, 1'b0)
        temp(16'hF000);
        `CHK(alert_w, 1'b1)
        host.write_reg({4'h9, strap}, 8'h01, 16'h0400, nak);
        `CHK(alert_w, 1'b0)
        host.write_reg({4'h9, strap}, 8'h01, 16'h0600, nak);
        temp(16'h0800);
        `CHK(alert_w, 1'b1)
        temp(16'h0000);
        `CHK(alert_w, 1'b1)
        host.read_reg({4'h9, strap}, 8'h00, rd);
        `CHK(alert_w, 1'b0)
        end_of_test;
    end
endmodule : tb_top
